// ---- core/hbsx_pkg.sv ----
// package: constants and types of the sixteen-bit host bus, non-muxed mode
package hbsx_pkg;
    // ========================================================
    // mode selection
    localparam logic [3:0] HBSX_IF_MODE_HOST_BUS = 4'h3;
    localparam logic [1:0] HBSX_HB_MODE_NONMUX = 2'h1;
    localparam logic HBSX_BYTE_SEL_OFF = 1'h1;
    // ========================================================
    // select schemes
    localparam logic [2:0] HBSX_SCH_ALE = 3'h0;
    localparam logic [2:0] HBSX_SCH_CS1 = 3'h1;
    localparam logic [2:0] HBSX_SCH_CS2 = 3'h2;
    localparam logic [2:0] HBSX_SCH_ALE_CS2 = 3'h3;
    localparam logic [2:0] HBSX_SCH_CS3 = 3'h4;
    localparam logic [2:0] HBSX_SCH_CS4 = 3'h5;
    // ========================================================
    // interface signal positions
    localparam int HBSX_PINS = 42;
    localparam int HBSX_DATA_W = 16;
    localparam int HBSX_ADDR_W = 21;
    localparam int HBSX_PIN_ADDR0 = 16;
    localparam int HBSX_BASE_ADDR_BITS = 12;
    localparam int HBSX_PIN_BSEL0 = 24;
    localparam int HBSX_PIN_BSEL1 = 25;
    localparam int HBSX_PIN_CS0_ALT = 26;
    localparam int HBSX_PIN_CS1 = 27;
    localparam int HBSX_PIN_RD = 28;
    localparam int HBSX_PIN_WR = 29;
    localparam int HBSX_PIN_ALE_CS0 = 30;
    localparam int HBSX_PIN_CS2 = 31;
    localparam int HBSX_PIN_READY = 32;
    localparam int HBSX_PIN_EXT = 33;
    localparam int HBSX_PIN_EXT_ADDR = 34;
    localparam int HBSX_EXT_ADDR_LO = 12;
    localparam int HBSX_EXT_ADDR_BITS = 8;
    localparam int HBSX_ADDR_TOP = 20;
    // ========================================================
    // bus cycle states, gray along idle-addr-data-done
    typedef enum logic [1:0] {
        HBSX_IDLE = 2'h0,
        HBSX_ADDR = 2'h1,
        HBSX_DATA = 2'h3,
        HBSX_DONE = 2'h2
    } hbsx_state_t;
    // ========================================================
    // configuration bundle
    typedef struct packed {
        logic [3:0] interfaceMode;
        logic [1:0] hostBusMode;
        logic byteLaneSelect;
        logic [2:0] selectScheme;
    } hbsx_cfg_t;
    // request bundle
    typedef struct packed {
        logic write;
        logic [1:0] target;
        logic [HBSX_ADDR_W-1:0] addr;
        logic [1:0] byteEn;
        logic [HBSX_DATA_W-1:0] wdata;
    } hbsx_req_t;
    // pin-side strobes, active high
    typedef struct packed {
        logic ale;
        logic rd;
        logic wr;
        logic [3:0] cs;
        logic [1:0] byte_lane_select;
    } hbsx_strobe_t;
endpackage

// ---- core/hbsx_pin_map.sv ----
// pin map: places address, data and strobes onto the interface signals
`timescale 1ns/1ps
`default_nettype none
module hbsx_pin_map
    import hbsx_pkg::*;
(
    // configuration
    input wire logic enabled,
    input wire logic [2:0] selectScheme,
    input wire logic byteSelOn,
    // bus content
    input wire logic [HBSX_ADDR_W-1:0] addr,
    input wire hbsx_strobe_t strobes,
    input wire logic [HBSX_DATA_W-1:0] dataOut,
    input wire logic dataOe,
    // interface signals
    output logic [HBSX_PINS-1:0] pinOut,
    output logic [HBSX_PINS-1:0] pinOe
);
    // ========================================================
    // mapping
    always_comb
    begin
        pinOut = '0;
        pinOe = '0;
        pinOut[HBSX_DATA_W-1:0] = dataOut;
        pinOe[HBSX_DATA_W-1:0] = {HBSX_DATA_W{dataOe}};
        for (int i = 0; i < HBSX_BASE_ADDR_BITS; i++)
        begin
            pinOut[HBSX_PIN_ADDR0+i] = addr[i];
            pinOe[HBSX_PIN_ADDR0+i] = 1'b1;
        end
        pinOut[HBSX_PIN_RD] = strobes.rd;
        pinOut[HBSX_PIN_WR] = strobes.wr;
        pinOe[HBSX_PIN_RD] = 1'b1;
        pinOe[HBSX_PIN_WR] = 1'b1;
        pinOe[HBSX_PIN_ALE_CS0] = 1'b1;
        case (selectScheme)
            HBSX_SCH_ALE:
                pinOut[HBSX_PIN_ALE_CS0] = strobes.ale;
            HBSX_SCH_CS1:
                pinOut[HBSX_PIN_ALE_CS0] = strobes.cs[0];
            HBSX_SCH_CS2:
            begin
                pinOut[HBSX_PIN_ALE_CS0] = strobes.cs[0];
                pinOut[HBSX_PIN_CS1] = strobes.cs[1];
            end
            HBSX_SCH_ALE_CS2:
            begin
                pinOut[HBSX_PIN_ALE_CS0] = strobes.ale;
                pinOut[HBSX_PIN_CS0_ALT] = strobes.cs[0];
                pinOut[HBSX_PIN_CS1] = strobes.cs[1];
            end
            HBSX_SCH_CS3, HBSX_SCH_CS4:
            begin
                // ten extra signals: cs2, pin 33 and eight address bits
                pinOut[HBSX_PIN_ALE_CS0] = strobes.cs[0];
                pinOut[HBSX_PIN_CS1] = strobes.cs[1];
                pinOut[HBSX_PIN_CS2] = strobes.cs[2];
                pinOe[HBSX_PIN_CS2] = 1'b1;
                pinOe[HBSX_PIN_EXT] = 1'b1;
                pinOut[HBSX_PIN_EXT] = (selectScheme == HBSX_SCH_CS4) ?
                    strobes.cs[3] : addr[HBSX_ADDR_TOP];
                for (int i = 0; i < HBSX_EXT_ADDR_BITS; i++)
                begin
                    pinOut[HBSX_PIN_EXT_ADDR+i] = addr[HBSX_EXT_ADDR_LO+i];
                    pinOe[HBSX_PIN_EXT_ADDR+i] = 1'b1;
                end
            end
            default:
                pinOut[HBSX_PIN_ALE_CS0] = 1'b0;
        endcase
        if (byteSelOn)
        begin
            pinOut[HBSX_PIN_BSEL0] = strobes.byte_lane_select[0];
            pinOut[HBSX_PIN_BSEL1] = strobes.byte_lane_select[1];
        end
        if (!enabled)
        begin
            // idle mode: every signal released so other functions may own it
            pinOe = '0;
        end
    end
endmodule
`default_nettype wire

// ---- core/hbsx_host_bus.sv ----
// host bus master: sixteen-bit non-multiplexed bus cycles
// ============================================================
`timescale 1ns/1ps
`default_nettype none
module hbsx_host_bus
    import hbsx_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration
    input wire hbsx_cfg_t cfg,
    // request side
    input wire logic reqValid,
    input wire hbsx_req_t req,
    output logic reqReady,
    // answer side
    output logic rspValid,
    output logic [HBSX_DATA_W-1:0] rspData,
    // status
    output logic busActive,
    // interface signals
    input wire logic [HBSX_PINS-1:0] pinIn,
    output logic [HBSX_PINS-1:0] pinOut,
    output logic [HBSX_PINS-1:0] pinOe
);
    // ========================================================
    // decoding helpers
    // ready table, one entry per scheme
    function automatic logic readyHonoured(input logic [2:0] sch);
        case (sch)
            // the latch-strobe-only scheme has no spare signal for ready
            HBSX_SCH_ALE: readyHonoured = 1'b0;
            HBSX_SCH_CS1: readyHonoured = 1'b1;
            HBSX_SCH_CS2: readyHonoured = 1'b1;
            HBSX_SCH_ALE_CS2: readyHonoured = 1'b1;
            HBSX_SCH_CS3: readyHonoured = 1'b1;
            HBSX_SCH_CS4: readyHonoured = 1'b1;
            default: readyHonoured = 1'b1;
        endcase
    endfunction

    // number of chip selects each scheme offers
    function automatic logic [2:0] csLimit(input logic [2:0] sch);
        case (sch)
            HBSX_SCH_CS1: csLimit = 3'h1;
            HBSX_SCH_CS2: csLimit = 3'h2;
            HBSX_SCH_ALE_CS2: csLimit = 3'h2;
            HBSX_SCH_CS3: csLimit = 3'h3;
            HBSX_SCH_CS4: csLimit = 3'h4;
            default: csLimit = 3'h0;
        endcase
    endfunction

    // schemes that carry the address latch strobe
    function automatic logic hasAle(input logic [2:0] sch);
        case (sch)
            HBSX_SCH_ALE: hasAle = 1'b1;
            HBSX_SCH_ALE_CS2: hasAle = 1'b1;
            default: hasAle = 1'b0;
        endcase
    endfunction

    // ========================================================
    // mode
    logic enabled;
    logic byteSelOn;
    logic readyOk;
    assign enabled = (cfg.interfaceMode == HBSX_IF_MODE_HOST_BUS) &&
                     (cfg.hostBusMode == HBSX_HB_MODE_NONMUX);
    assign byteSelOn = (cfg.byteLaneSelect != HBSX_BYTE_SEL_OFF);
    assign readyOk = !readyHonoured(cfg.selectScheme) ||
                     pinIn[HBSX_PIN_READY];

    // ========================================================
    // cycle sequencer
    hbsx_state_t state_q;
    hbsx_state_t state_d;
    hbsx_req_t cur_q;
    hbsx_strobe_t strobes;
    logic [HBSX_DATA_W-1:0] rdata_q;
    logic take;
    logic inAddr;
    logic inData;
    logic sampleRead;
    logic dataDrive;

    assign reqReady = enabled && (state_q == HBSX_IDLE);
    assign busActive = (state_q != HBSX_IDLE);
    assign take = reqValid && reqReady;
    assign inAddr = (state_q == HBSX_ADDR);
    assign inData = (state_q == HBSX_DATA);

    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            HBSX_IDLE:
                if (take)
                begin
                    state_d = HBSX_ADDR;
                end
            HBSX_ADDR:
                state_d = HBSX_DATA;
            HBSX_DATA:
                // a slow peripheral keeps the cycle here
                if (readyOk)
                begin
                    state_d = HBSX_DONE;
                end
            HBSX_DONE:
                state_d = HBSX_IDLE;
            default:
                state_d = HBSX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= HBSX_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // request held whole until the cycle ends
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cur_q <= '0;
        end
        else if (take)
        begin
            cur_q <= req;
        end
    end

    // ========================================================
    // read response
    // read data sampled only once ready is seen
    assign sampleRead = inData && readyOk && !cur_q.write;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else if (sampleRead)
        begin
            rdata_q <= pinIn[HBSX_DATA_W-1:0];
        end
    end

    assign rspValid = (state_q == HBSX_DONE);
    assign rspData = rdata_q;

    // ========================================================
    // chip select decode, one slice per select
    logic [2:0] csCount;
    logic [3:0] csHit;
    assign csCount = csLimit(cfg.selectScheme);
    for (genvar g = 0; g < 4; g++)
    begin : g_cs
        // a target beyond the scheme's selects drives none of them
        assign csHit[g] = (cur_q.target == 2'(g)) &&
                          (3'(g) < csCount);
    end

    // ========================================================
    // strobes
    // write data owns the data lines in ADDR and DATA only; releasing
    // them in DONE keeps a following read from fighting the peripheral
    assign dataDrive = cur_q.write && (inAddr || inData);

    always_comb
    begin
        strobes = '0;
        strobes.ale = inAddr && hasAle(cfg.selectScheme);
        strobes.rd = inData && !cur_q.write;
        strobes.wr = inData && cur_q.write;
        if (inAddr || inData)
        begin
            strobes.cs = csHit;
            strobes.byte_lane_select = cur_q.byteEn;
        end
    end

    // ========================================================
    // pin placement
    hbsx_pin_map u_map (
        .enabled(enabled),
        .selectScheme(cfg.selectScheme),
        .byteSelOn(byteSelOn),
        .addr(cur_q.addr),
        .strobes(strobes),
        .dataOut(cur_q.wdata),
        .dataOe(dataDrive),
        .pinOut(pinOut),
        .pinOe(pinOe)
    );
endmodule
`default_nettype wire

// ---- test/hbsx_periph_model.sv ----
// peripheral model: word store behind the bus, with a stretchable ready
`timescale 1ns/1ps
`default_nettype none
module hbsx_periph_model
    import hbsx_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // interface signals
    input wire logic [HBSX_PINS-1:0] pinOut,
    input wire logic [3:0] waitCycles,
    output logic [HBSX_PINS-1:0] pinIn
);
    // ========================================================
    // storage and ready
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [3:0] cnt;
    logic strobe;
    logic rdy;
    assign strobe = pinOut[HBSX_PIN_RD] | pinOut[HBSX_PIN_WR];
    assign rdy = strobe && cnt >= waitCycles;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            cnt <= 4'h0;
        else if (strobe && !rdy)
            cnt <= cnt + 4'h1;
        else
            cnt <= 4'h0;
    end
    // address is held by the master through the data phase
    always_ff @(posedge core_clk)
    begin
        if (pinOut[HBSX_PIN_WR])
            mem[pinOut[19:16]] <= pinOut[15:0];
        last <= pinIn[15:0];
    end
    // released data lines show a changing pattern, not the last word
    always_comb
    begin
        pinIn = '0;
        pinIn[15:0] = pinOut[HBSX_PIN_RD] ? mem[pinOut[19:16]] : ~last;
        pinIn[HBSX_PIN_READY] = rdy;
    end
endmodule
`default_nettype wire

// ---- test/hbsx_bus_monitor.sv ----
// checker: pin-level properties of the host bus master
`timescale 1ns/1ps
`default_nettype none
module hbsx_bus_monitor
    import hbsx_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration, request and answer
    input wire hbsx_cfg_t cfg,
    input wire logic reqValid,
    input wire hbsx_req_t req,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [HBSX_DATA_W-1:0] rspData,
    input wire logic busActive,
    // interface signals
    input wire logic [HBSX_PINS-1:0] pinIn,
    input wire logic [HBSX_PINS-1:0] pinOut,
    input wire logic [HBSX_PINS-1:0] pinOe
);
    logic stb;
    logic en;
    logic rdyOk;
    logic s0;
    assign stb = pinOut[HBSX_PIN_RD] | pinOut[HBSX_PIN_WR];
    assign en = cfg.interfaceMode == HBSX_IF_MODE_HOST_BUS
        && cfg.hostBusMode == HBSX_HB_MODE_NONMUX;
    assign s0 = cfg.selectScheme == HBSX_SCH_ALE;
    // ready is not honoured in the latch-only scheme
    assign rdyOk = pinIn[HBSX_PIN_READY] | s0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ========================================================
    // properties
    refuse_off_a: assert property (!en |-> !reqReady && pinOe == '0)
        else $error("bus served while disabled");
    take_walk_a: assert property (reqValid && reqReady |=> busActive ##1 stb)
        else $error("data phase late after take");
    cycle_end_a: assert property (stb && rdyOk |=> rspValid && !stb)
        else $error("cycle did not end on ready");
    stretch_hold_a: assert property (stb && !rdyOk |=>
        stb && !rspValid && $stable(pinOut[31:16]))
        else $error("cycle not held while not ready");
    read_sample_a: assert property (rspValid && $past(pinOut[HBSX_PIN_RD])
        |-> rspData == $past(pinIn[15:0]))
        else $error("read data not taken at ready");
    ale_pulse_a: assert property (s0 && pinOut[HBSX_PIN_ALE_CS0] |=>
        !pinOut[HBSX_PIN_ALE_CS0] && stb && $stable(pinOut[27:16]))
        else $error("latch strobe not a one-cycle mark");
    addr_map_a: assert property (reqValid && reqReady |=>
        pinOut[23:16] == $past(req.addr[7:0]) && pinOut[25:24] ==
        (cfg.byteLaneSelect ? $past(req.addr[9:8]) : $past(req.byteEn)))
        else $error("address or lane selects misplaced");
    one_select_a: assert property (cfg.selectScheme == HBSX_SCH_CS4 && stb
        |-> $onehot({pinOut[33], pinOut[31], pinOut[30], pinOut[27]}))
        else $error("chip selects not one-hot");
    read_release_a: assert property (pinOut[HBSX_PIN_RD] |->
        pinOe[15:0] == '0 && !pinOut[HBSX_PIN_WR])
        else $error("data driven during read");
endmodule
bind hbsx_host_bus hbsx_bus_monitor i_mon (.core_clk(core_clk), .rst(rst),
    .cfg(cfg), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .busActive(busActive),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// ---- test/tb.sv ----
// testbench: bus cycles in every scheme, with and without lane selects
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hbsx_pkg::*;
    logic core_clk, rst, reqValid, reqReady, rspValid, busActive;
    hbsx_cfg_t cfg;
    hbsx_req_t req;
    logic [15:0] rspData, d;
    logic [20:0] a;
    logic [HBSX_PINS-1:0] pinIn, pinOut, pinOe, seenPins;
    logic [3:0] waitCycles;
    int err_total, checks_done, s, b, t;
    int nCs [6] = '{1, 1, 2, 2, 3, 4};
    int csTab [6][4] = '{'{30, 30, 30, 30}, '{30, 30, 30, 30},
        '{30, 27, 27, 27}, '{26, 27, 27, 27}, '{30, 27, 31, 31},
        '{30, 27, 31, 33}};
    hbsx_host_bus i_dut (.core_clk(core_clk), .rst(rst), .cfg(cfg),
        .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .busActive(busActive),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    hbsx_periph_model i_peer (.core_clk(core_clk), .rst(rst),
        .pinOut(pinOut), .waitCycles(waitCycles), .pinIn(pinIn));
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ========================================================
    // tasks
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // every wait is bounded; running out ends the run
    task tick(inout int n);
        @(negedge core_clk);
        n++;
        if (n > 50)
        begin
            err_total++;
            wrap_up();
        end
    endtask
    task access(input logic wr, input logic [1:0] tg, input logic [1:0] be);
        int n;
        n = 0;
        while (reqReady !== 1'b1)
            tick(n);
        req = '{wr, tg, a, be, d};
        reqValid = 1'b1;
        @(negedge core_clk);
        reqValid = 1'b0;
        while (pinOut[HBSX_PIN_RD] !== 1'b1 && pinOut[HBSX_PIN_WR] !== 1'b1)
            tick(n);
        seenPins = pinOut;
        check(busActive, 1'b1);
        while (rspValid !== 1'b1)
            tick(n);
        check(seenPins[HBSX_PIN_WR], wr);
        if (!wr)
            check(rspData, d);
    endtask
    // ========================================================
    // sequence
    initial
    begin
        cfg = '{4'h3, 2'h1, 1'h1, 3'h0};
        req = '0;
        reqValid = 1'b0;
        waitCycles = 4'h0;
        err_total = 0;
        checks_done = 0;
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        cfg.interfaceMode = 4'h0;
        @(negedge core_clk);
        check(reqReady, 1'b0);
        check(pinOe, '0);
        cfg = '{4'h3, 2'h0, 1'h1, 3'h0};
        @(negedge core_clk);
        check(reqReady, 1'b0);
        cfg.hostBusMode = 2'h1;
        for (s = 0; s < 6; s++)
            for (b = 0; b < 2; b++)
            begin
                cfg.selectScheme = s[2:0];
                cfg.byteLaneSelect = b[0];
                waitCycles = b ? 4'h0 : 4'h3;
                t = nCs[s] - 1;
                a = 21'h15a5a0 + 21'(s * 2 + b);
                d = 16'hc3a0 + 16'(s * 2 + b);
                access(1'b1, t[1:0], 2'h3);
                check(seenPins[15:0], d);
                check(seenPins[23:16], a[7:0]);
                check(seenPins[25:24], b ? a[9:8] : 2'h3);
                check(seenPins[csTab[s][t]], s != 0);
                check(pinOe[41:34], s >= 4 ? 8'hff : 8'h00);
                if (s >= 4)
                    check(seenPins[41:34], a[19:12]);
                access(1'b0, t[1:0], 2'h1);
            end
        // unused scheme code: no select, the cycle still runs
        cfg.selectScheme = 3'h6;
        access(1'b1, 2'h0, 2'h3);
        check(seenPins[30], 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
